// ---- rbr_request_builder.sv ----
// I2C-over-AUX request framer with its register port
// ==========================================================================
// Notes on behaviour
// R01 - Software sets target address before any request
// R02 - Software loads payload bytes before write command
// R03 - Command write launches; bits 3:0 give length
// R04 - Write frame: start, cmd, address, length, data, stop
// R05 - Read frame ends with stop, no data
// R06 - Read launched by command write, FIFO untouched
// R07 - Sink sends start, address, direction, data
// R08 - Sink continues same-device writes without start
// R09 - Write without hold flag ends with stop
// R10 - Read stop depends on hold flag
// R11 - Bit 12 sends command and address only
// R12 - Command nibble bits 11:8 encodes six kinds
// R13 - Software waits for reply before next request
// R14 - Payload bytes leave in load order
`timescale 1ns/1ps
`include "rbr_regs.svh"

module rbr_request_builder #(
  parameter int FIFO_DEPTH = `RBR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input rbr_pkg::rbr_bus_req_t busReq,
  output logic [31:0] busRdata,
  output rbr_pkg::rbr_sym_t linkSym,
  input wire logic linkReady,
  output logic busy
);
  import rbr_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ==========================================================================
  // Register port
  rbr_state_t state_q, state_d;
  rbr_cmd_word_t cmd_q, cmd_d;
  rbr_sym_t sym_q, sym_d;
  rbr_plan_t plan;
  logic [19:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic overflow_q, overflow_d;
  logic [4:0] remain_q, remain_d;
  logic wrCmd, wrFifo, wrAddr, wrStat;
  logic launch, fire, pop;
  logic [7:0] popData;
  logic [LW-1:0] level;
  logic full, empty;

  always_comb begin
    wrCmd = busReq.wr && (busReq.addr == `RBR_OFF_CMD);
    wrFifo = busReq.wr && (busReq.addr == `RBR_OFF_FIFO);
    wrAddr = busReq.wr && (busReq.addr == `RBR_OFF_ADDR);
    wrStat = busReq.wr && (busReq.addr == `RBR_OFF_STAT);
    // Commands during a frame are dropped; software must wait for reply
    launch = wrCmd && (state_q == RBR_ST_IDLE); // R03 R06
    addr_d = wrAddr ? busReq.wdata[19:0] : addr_q; // R01
    // Set wins over the software clear
    overflow_d = overflow_q;
    if (wrStat && busReq.wdata[`RBR_STAT_OVF]) begin
      overflow_d = 1'b0;
    end
    if (wrFifo && full) begin
      overflow_d = 1'b1;
    end
    rdata_d = '0;
    if (busReq.rd) begin
      case (busReq.addr)
        `RBR_OFF_ADDR: rdata_d[19:0] = addr_q;
        `RBR_OFF_STAT: begin
          rdata_d[`RBR_STAT_BUSY] = busy;
          rdata_d[`RBR_STAT_OVF] = overflow_q;
          rdata_d[`RBR_STAT_LVL_LSB +: LW] = level;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= `RBR_ADDR_RST;
      overflow_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      addr_q <= addr_d;
      overflow_q <= overflow_d;
      rdata_q <= rdata_d;
    end
  end

  assign busRdata = rdata_q;

  // ==========================================================================
  // Payload store and command decode
  rbr_payload_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .rstn(rstn),
    .push(wrFifo), // R02
    .pushData(busReq.wdata[7:0]),
    .pop(pop),
    .popData(popData),
    .level(level),
    .full(full),
    .empty(empty)
  );

  rbr_cmd_decode uDecode (
    .cmdWord(cmd_q),
    .plan(plan)
  );

  // ==========================================================================
  // Frame sequencer
  // One symbol is presented at a time; it advances when the link takes it
  always_comb begin
    fire = sym_q.valid && linkReady;
    state_d = state_q;
    cmd_d = cmd_q;
    sym_d = sym_q;
    remain_d = remain_q;
    pop = 1'b0;
    case (state_q)
      RBR_ST_IDLE: begin
        if (launch) begin
          cmd_d = rbr_cmd_word_t'(busReq.wdata);
          sym_d = '{valid: 1'b1, kind: RBR_SYM_START, data: 8'h00};
          state_d = RBR_ST_START;
        end
      end
      RBR_ST_START: begin
        if (fire) begin
          sym_d.kind = RBR_SYM_BYTE;
          sym_d.data = {cmd_q.rsvdCode, cmd_q.holdBusOpenFlag,
                        cmd_q.opcode, addr_q[19:16]}; // R12
          state_d = RBR_ST_CMD;
        end
      end
      RBR_ST_CMD: begin
        if (fire) begin
          sym_d.data = addr_q[15:8];
          state_d = RBR_ST_ADDRH;
        end
      end
      RBR_ST_ADDRH: begin
        if (fire) begin
          sym_d.data = addr_q[7:0];
          state_d = RBR_ST_ADDRL;
        end
      end
      RBR_ST_ADDRL: begin
        if (fire) begin
          if (plan.sendLen) begin
            sym_d.data = {4'h0, cmd_q.len}; // R03
            state_d = RBR_ST_LEN;
          end else begin
            sym_d = '{valid: 1'b1, kind: RBR_SYM_STOP, data: 8'h00}; // R11
            state_d = RBR_ST_STOP;
          end
        end
      end
      RBR_ST_LEN: begin
        if (fire) begin
          if (plan.sendData) begin
            // An empty FIFO sends zero bytes rather than stalling
            sym_d.data = empty ? 8'h00 : popData; // R14
            pop = !empty;
            remain_d = plan.dataBytes - 5'h01;
            state_d = RBR_ST_DATA; // R04
          end else begin
            sym_d = '{valid: 1'b1, kind: RBR_SYM_STOP, data: 8'h00}; // R05
            state_d = RBR_ST_STOP;
          end
        end
      end
      RBR_ST_DATA: begin
        if (fire) begin
          if (remain_q == 5'h00) begin
            sym_d = '{valid: 1'b1, kind: RBR_SYM_STOP, data: 8'h00};
            state_d = RBR_ST_STOP;
          end else begin
            sym_d.data = empty ? 8'h00 : popData; // R14
            pop = !empty;
            remain_d = remain_q - 5'h01;
          end
        end
      end
      RBR_ST_STOP: begin
        if (fire) begin
          sym_d = '{valid: 1'b0, kind: RBR_SYM_START, data: 8'h00};
          state_d = RBR_ST_IDLE;
        end
      end
      default: begin
        sym_d = '0;
        state_d = RBR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RBR_ST_IDLE;
      cmd_q <= '0;
      sym_q <= '0;
      remain_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      sym_q <= sym_d;
      remain_q <= remain_d;
    end
  end

  assign linkSym = sym_q;
  assign busy = (state_q != RBR_ST_IDLE);

  // ==========================================================================
  // Checks
  // Counts data bytes taken, so a short or long burst is caught
  logic [4:0] dataSeen_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataSeen_q <= '0;
    end else if (state_q == RBR_ST_IDLE) begin
      dataSeen_q <= '0;
    end else if (fire && state_q == RBR_ST_DATA) begin
      dataSeen_q <= dataSeen_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  launchStart_a: assert property (launch |=> linkSym.valid // R03
    && linkSym.kind == RBR_SYM_START && busy)
    else $error("command write did not open a frame");

  cmdNibble_a: assert property ((state_q == RBR_ST_CMD) |-> // R12
    linkSym.data[7:4] == {cmd_q.rsvdCode, cmd_q.holdBusOpenFlag,
                          cmd_q.opcode})
    else $error("command byte does not carry the command nibble");

  addrHigh_a: assert property ((state_q == RBR_ST_ADDRH) |-> // R04
    linkSym.data == addr_q[15:8])
    else $error("address high byte differs from the address register");

  addrLow_a: assert property ((state_q == RBR_ST_ADDRL) |-> // R04
    linkSym.data == addr_q[7:0])
    else $error("address low byte differs from the address register");

  lenByte_a: assert property ((state_q == RBR_ST_LEN) |-> // R03
    linkSym.data == {4'h0, cmd_q.len})
    else $error("length byte differs from command length field");

  addrOnlyStop_a: assert property ((state_q == RBR_ST_ADDRL && fire // R11
    && cmd_q.addrOnly) |=> linkSym.kind == RBR_SYM_STOP)
    else $error("address-only request sent a length byte");

  readNoData_a: assert property ((state_q == RBR_ST_LEN && fire // R05
    && rbr_code_t'({2'b00, cmd_q.opcode}) == RBR_I2C_RD)
    |=> state_q == RBR_ST_STOP)
    else $error("read request carried data bytes");

  writeCount_a: assert property ((state_q == RBR_ST_STOP && fire // R04
    && plan.sendData) |-> dataSeen_q == plan.dataBytes)
    else $error("write frame data count wrong");

  dataOrder_a: assert property (pop |=> linkSym.data == $past(popData)) // R14
    else $error("data byte is not the oldest loaded byte");

  idleQuiet_a: assert property (!busy |-> !linkSym.valid) // R04
    else $error("symbol offered outside a frame");

  cmdHeld_a: assert property ((busy && wrCmd) |=> $stable(cmd_q)) // R06
    else $error("command changed during a frame");

  stallHold_a: assert property ((linkSym.valid && !linkReady) |=> // R04
    $stable(linkSym))
    else $error("symbol changed while the link stalled");

  // Read data must stand exactly in the cycle after the strobe
  addrRead_a: assert property ((busReq.rd // R01
    && busReq.addr == `RBR_OFF_ADDR) |=> busRdata[19:0] == $past(addr_q))
    else $error("address register read back wrong");

  overflowSet_a: assert property ((wrFifo && full) |=> overflow_q) // R02
    else $error("write into a full payload store was not flagged");

  writeFrame_c: cover property (state_q == RBR_ST_DATA && fire
    && remain_q == 5'h00);
  readFrame_c: cover property (state_q == RBR_ST_LEN && fire
    && !plan.sendData);
  addrOnly_c: cover property (state_q == RBR_ST_ADDRL && fire
    && cmd_q.addrOnly);
  stall_c: cover property (linkSym.valid && !linkReady);
  holdFrame_c: cover property (state_q == RBR_ST_STOP && fire
    && cmd_q.holdBusOpenFlag);

endmodule : rbr_request_builder

// ---- rbr_regs.svh ----
// Register offsets, field positions and reset values of the request builder
`ifndef RBR_REGS_SVH
`define RBR_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define RBR_OFF_CMD 12'h100
`define RBR_OFF_FIFO 12'h104
`define RBR_OFF_ADDR 12'h108
`define RBR_OFF_STAT 12'h110

// ==========================================================================
// Reset values and field positions
`define RBR_ADDR_RST 20'h0_0000
`define RBR_STAT_BUSY 0
`define RBR_STAT_OVF 1
`define RBR_STAT_LVL_LSB 4
`define RBR_FIFO_DEPTH 16
`define RBR_LEN_BIAS 5'h01

`endif

// ---- rbr_pkg.sv ----
// Types shared by the request builder modules
package rbr_pkg;

  // ========================================================================
  // Command word
  typedef enum logic [3:0] {
    RBR_I2C_WR = 4'h0,
    RBR_I2C_RD = 4'h1,
    RBR_I2C_WST = 4'h2,
    RBR_I2C_WR_HOLD = 4'h4,
    RBR_I2C_RD_HOLD = 4'h5,
    RBR_I2C_WST_HOLD = 4'h6
  } rbr_code_t;

  typedef struct packed {
    logic [18:0] rsvdHi;
    logic addrOnly;
    logic rsvdCode;
    logic holdBusOpenFlag;
    logic [1:0] opcode;
    logic [3:0] rsvdLo;
    logic [3:0] len;
  } rbr_cmd_word_t;

  typedef struct packed {
    logic sendLen;
    logic sendData;
    logic [4:0] dataBytes;
  } rbr_plan_t;

  // ========================================================================
  // Register port and link symbols
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rbr_bus_req_t;

  typedef enum logic [1:0] {
    RBR_SYM_START = 2'h0,
    RBR_SYM_BYTE = 2'h1,
    RBR_SYM_STOP = 2'h2
  } rbr_kind_t;

  typedef struct packed {
    logic valid;
    rbr_kind_t kind;
    logic [7:0] data;
  } rbr_sym_t;

  // Gray along start, cmd, address, length, data, stop
  typedef enum logic [2:0] {
    RBR_ST_IDLE = 3'b000,
    RBR_ST_START = 3'b001,
    RBR_ST_CMD = 3'b011,
    RBR_ST_ADDRH = 3'b010,
    RBR_ST_ADDRL = 3'b110,
    RBR_ST_LEN = 3'b111,
    RBR_ST_DATA = 3'b101,
    RBR_ST_STOP = 3'b100
  } rbr_state_t;

endpackage : rbr_pkg

// ---- rbr_payload_fifo.sv ----
// Payload byte FIFO feeding the data phase of a write request
`timescale 1ns/1ps
`include "rbr_regs.svh"

module rbr_payload_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `RBR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  output logic [WIDTH-1:0] popData,
  output logic [$clog2(DEPTH):0] level,
  output logic full,
  output logic empty
);
  import rbr_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] level_q, level_d;
  logic doPush, doPop;

  // ========================================================================
  // Pointers
  always_comb begin
    doPush = push && !full;
    doPop = pop && !empty;
    wrPtr_d = doPush ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = doPop ? rdPtr_q + 1'b1 : rdPtr_q;
    level_d = level_q;
    if (doPush && !doPop) begin
      level_d = level_q + 1'b1;
    end else if (doPop && !doPush) begin
      level_d = level_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      level_q <= level_d;
    end
  end

  // No reset on storage: contents are only read behind a valid level
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  assign popData = mem[rdPtr_q];
  assign level = level_q;
  assign full = (level_q == DEPTH[AW:0]);
  assign empty = (level_q == '0);

  // ========================================================================
  // Checks
  fifoOrder_a: assert property (@(posedge clk) disable iff (!rstn) // R14
    (push && empty && !pop) |=> (popData == $past(pushData)))
    else $error("first byte loaded is not the first byte out");

endmodule : rbr_payload_fifo

// ---- rbr_cmd_decode.sv ----
// Decodes a command word into the shape of the request frame
`timescale 1ns/1ps

module rbr_cmd_decode (
  input rbr_pkg::rbr_cmd_word_t cmdWord,
  output rbr_pkg::rbr_plan_t plan
);
  import rbr_pkg::*;

  logic isWrite;
  logic isRead;

  always_comb begin
    isWrite = (rbr_code_t'({2'b00, cmdWord.opcode}) == RBR_I2C_WR);
    isRead = (rbr_code_t'({2'b00, cmdWord.opcode}) == RBR_I2C_RD);
    // Address-only and status requests carry no length byte
    plan.sendLen = (isWrite || isRead) && !cmdWord.addrOnly; // R11
    // Reads never carry payload in the request
    plan.sendData = isWrite && !cmdWord.addrOnly; // R04 R05
    plan.dataBytes = {1'b0, cmdWord.len} + `RBR_LEN_BIAS; // R03
  end

endmodule : rbr_cmd_decode

// ---- rbr_sink_model.sv ----
// Far-end model: takes link symbols and tracks the bridged I2C bus state
`timescale 1ns/1ps

module rbr_sink_model (
  input wire logic clk,
  input wire logic rstn,
  input rbr_pkg::rbr_sym_t linkSym,
  input wire logic stall,
  output logic linkReady
);
  import rbr_pkg::*;
  // ==========================================================================
  // Symbol capture and bridge bookkeeping
  logic [9:0] got[$];
  int frameIdx = 0;
  int i2cStarts = 0;
  int i2cStops = 0;
  logic busOpen = 1'b0;
  logic [19:0] lastAddr = 20'h0_0000;
  logic [3:0] code;
  logic [19:0] addr;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      linkReady <= 1'b0;
    end else begin
      // Alternating ready makes every symbol after the first of a frame wait one cycle
      linkReady <= stall ? !linkReady : 1'b1;
      if (linkSym.valid && linkReady) begin
        if (linkSym.kind == RBR_SYM_START) frameIdx = got.size();
        got.push_back({linkSym.kind, linkSym.data});
        if (linkSym.kind == RBR_SYM_STOP) begin
          code = got[frameIdx + 1][7:4];
          addr = {got[frameIdx + 1][3:0], got[frameIdx + 2][7:0],
                  got[frameIdx + 3][7:0]};
          if (!code[1]) begin
            if (!busOpen || addr != lastAddr) i2cStarts++;
            lastAddr = addr;
            busOpen = code[2];
            if (!code[2]) i2cStops++;
          end
        end
      end
    end
  end
endmodule : rbr_sink_model

// ---- rbr_request_builder_test.sv ----
// Self-checking bench for the request framer and its register port
`timescale 1ns/1ps
`include "rbr_regs.svh"

module rbr_request_builder_test;
  import rbr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  rbr_bus_req_t busReq = '0;
  logic [31:0] busRdata;
  rbr_sym_t linkSym;
  logic linkReady;
  logic busy;
  logic stall = 1'b0;
  int num_errors = 0;
  int n_tests = 0;
  logic [9:0] exp[$];
  logic [31:0] rd;
  logic [3:0] codeTab[9] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'h2, 4'h6, 4'h0, 4'h5,
                             4'h0};
  logic [3:0] lenTab[9] = '{4'hF, 4'h2, 4'h7, 4'h0, 4'h3, 4'h1, 4'h3, 4'h2,
                            4'h1};
  logic flagTab[9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  int loadTab[9] = '{17, 3, 0, 0, 0, 0, 0, 0, 0};

  always #20 clk = ~clk;

  rbr_request_builder #(.FIFO_DEPTH(16)) dut (
    .clk(clk),
    .rstn(rstn),
    .busReq(busReq),
    .busRdata(busRdata),
    .linkSym(linkSym),
    .linkReady(linkReady),
    .busy(busy)
  );

  rbr_sink_model sink (
    .clk(clk),
    .rstn(rstn),
    .linkSym(linkSym),
    .stall(stall),
    .linkReady(linkReady)
  );

  // ==========================================================================
  // Access tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic busWr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    busReq <= '0;
  endtask : busWr

  task automatic busRd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    busReq <= '0;
    #1;
    d = busRdata;
  endtask : busRd

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // One request: load, launch, optionally poke while busy, compare frame
  task automatic runFrame(input logic [3:0] code, input logic flagA,
                          input logic [3:0] len, input int nLoad,
                          input logic poke);
    logic [7:0] pay[$];
    logic [19:0] a;
    logic [31:0] v;
    int k;
    sink.got.delete();
    exp.delete();
    a = 20'h5_A3C1 + 20'(code);
    busWr(`RBR_OFF_ADDR, {12'h000, a});
    for (k = 0; k < nLoad; k++) begin
      pay.push_back(8'(8'h30 + k) ^ {code, 4'h0});
      busWr(`RBR_OFF_FIFO, {24'h00_0000, pay[k]});
    end
    k = (nLoad > 16) ? 16 : nLoad;
    busRd(`RBR_OFF_STAT, rd);
    check("fifo status", rd, (k << 4) | ((nLoad > 16) << 1));
    if (nLoad > 16) begin
      busWr(`RBR_OFF_STAT, 32'h0000_0002);
      busRd(`RBR_OFF_STAT, rd);
      check("overflow clear", rd, k << 4);
    end
    busWr(`RBR_OFF_CMD, {19'h0_0000, flagA, code, 4'h0, len});
    if (poke) begin
      busRd(`RBR_OFF_STAT, rd);
      check("busy status", rd, 32'h0000_0001);
      busWr(`RBR_OFF_CMD, 32'h0000_0003);
    end
    exp.push_back({RBR_SYM_START, 8'h00});
    exp.push_back({RBR_SYM_BYTE, code, a[19:16]});
    exp.push_back({RBR_SYM_BYTE, a[15:8]});
    exp.push_back({RBR_SYM_BYTE, a[7:0]});
    if (!flagA && !code[1]) exp.push_back({RBR_SYM_BYTE, 4'h0, len});
    if (!flagA && code[1:0] == 2'h0) begin
      for (k = 0; k <= len; k++) begin
        v = (k < nLoad) ? pay[k] : 8'h00;
        exp.push_back({RBR_SYM_BYTE, v[7:0]});
      end
    end
    exp.push_back({RBR_SYM_STOP, 8'h00});
    for (k = 0; k < 400; k++) begin
      @(posedge clk);
      #1;
      if (busy !== 1'b1) break;
    end
    check("frame done", 32'(k < 400), 32'h0000_0001);
    repeat (4) @(posedge clk);
    check("frame size", sink.got.size(), exp.size());
    foreach (exp[j]) check("symbol", sink.got[j], exp[j]);
    $display("frame test code %h done", code);
  endtask : runFrame

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    busRd(`RBR_OFF_ADDR, rd);
    check("address reset", rd, 32'h0000_0000);
    busRd(`RBR_OFF_STAT, rd);
    check("status reset", rd, 32'h0000_0000);
    busRd(`RBR_OFF_CMD, rd);
    check("command read", rd, 32'h0000_0000);
    busRd(12'h1FC, rd);
    check("unmapped read", rd, 32'h0000_0000);
    busWr(`RBR_OFF_ADDR, 32'hFFFF_FFFF);
    busRd(`RBR_OFF_ADDR, rd);
    check("address width", rd, 32'h000F_FFFF);
    $display("register test done");
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      stall <= (i % 2) == 1;
      runFrame(codeTab[i], flagTab[i], lenTab[i], loadTab[i], i == 2);
    end
    check("bridge stops", sink.i2cStops, 4);
    check("bridge starts", sink.i2cStarts, 7);
    $display("bridge test done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule : rbr_request_builder_test
